//--- design/tsr_pkg.sv
package tsr_pkg;
   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam int TSR_ADDR_W = 3;
   localparam logic [2:0] TSR_ADDR_CAP = 3'h0;
   localparam logic [2:0] TSR_ADDR_SETUP = 3'h1;
   localparam logic [2:0] TSR_ADDR_UPPER = 3'h2;
   localparam logic [2:0] TSR_ADDR_LOWER = 3'h3;
   localparam logic [2:0] TSR_ADDR_CRIT = 3'h4;
   localparam logic [2:0] TSR_ADDR_TEMP = 3'h5;
   localparam logic [2:0] TSR_ADDR_MAKER = 3'h6;
   localparam logic [2:0] TSR_ADDR_PART = 3'h7;
   // ----------------------------------------
   // Reset values and masks
   // ----------------------------------------
   localparam logic [15:0] TSR_CAP_VALUE = 16'h0077;
   localparam logic [15:0] TSR_LIMIT_RESET = 16'h0000;
   localparam logic [15:0] TSR_LIMIT_MASK = 16'h1FFC;
   localparam logic [12:0] TSR_TEMP_RESET = 13'h0000;
   // ----------------------------------------
   // Setup register fields
   // ----------------------------------------
   localparam int TSR_SET_HYSTERESIS_SELECT_HI = 10;
   localparam int TSR_SET_HYSTERESIS_SELECT_LO = 9;
   localparam int TSR_SET_HALT = 8;
   localparam int TSR_SET_CRIT_FREEZE = 7;
   localparam int TSR_SET_ALARM_LOCK = 6;
   localparam int TSR_SET_CLEAR = 5;
   localparam int TSR_SET_STATE_COPY = 4;
   localparam int TSR_SET_ALERT_EN = 3;
   localparam int TSR_SET_CRIT_ONLY = 2;
   localparam int TSR_SET_POL = 1;
   localparam int TSR_SET_MODE = 0;
   // ----------------------------------------
   // Temperature register flags
   // ----------------------------------------
   localparam int TSR_TEMP_CRIT = 15;
   localparam int TSR_TEMP_HIGH = 14;
   localparam int TSR_TEMP_LOW = 13;
   // ----------------------------------------
   // Hysteresis in 0.0625 degC steps
   // ----------------------------------------
   localparam logic [14:0] TSR_HYSTERESIS_SELECT_NONE = 15'h0000;
   localparam logic [14:0] TSR_HYSTERESIS_SELECT_SMALL = 15'h0018;
   localparam logic [14:0] TSR_HYSTERESIS_SELECT_MID = 15'h0030;
   localparam logic [14:0] TSR_HYSTERESIS_SELECT_LARGE = 15'h0060;
endpackage : tsr_pkg

//--- design/tsr_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tsr_register_bank
#(
   parameter logic [15:0] MAKER_CODE = 16'h0A5C, // Arbitrary value
   parameter logic [15:0] PART_CODE = 16'h00F1 // Arbitrary value
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic ptr_wr,
   input wire logic [tsr_pkg::TSR_ADDR_W-1:0] ptr_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic conv_tick,
   input wire logic [12:0] conv_temp,
   output logic [15:0] rd_data_ff,
   output logic wr_ack_ff,
   output logic alert_out_ff,
   output logic alert_oe_ff
);
   import tsr_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [2:0] ptr_ff;
   logic [15:0] upper_ff;
   logic [15:0] lower_ff;
   logic [15:0] crit_ff;
   logic [12:0] temp_ff;
   logic [1:0] hysteresis_select_ff;
   logic halt_ff;
   logic crit_freeze_ff;
   logic alarm_lock_ff;
   logic alert_en_ff;
   logic crit_only_ff;
   logic pol_ff;
   logic mode_ff;
   logic tick_s1_ff;
   logic tick_s2_ff;
   logic tick_s3_ff;
   logic tick_lvl_ff;
   logic above_crit_ff;
   logic above_high_ff;
   logic below_low_ff;
   logic window_prev_ff;
   logic latch_ff;
   logic clr_pend_ff;
   logic event_ff;
   logic lock_any;
   logic tick_rise;
   logic wr_setup;
   logic clear_req;
   logic window_out;
   logic nxt_event;
   logic [14:0] hysteresis_select_amt;
   logic signed [14:0] t_s;
   logic signed [14:0] hi_s;
   logic signed [14:0] lo_s;
   logic signed [14:0] cr_s;
   logic signed [14:0] hy_s;
   logic [15:0] setup_rd;
   logic [15:0] nxt_rd_data;
   assign lock_any = crit_freeze_ff | alarm_lock_ff;
   assign wr_setup = reg_wr && (ptr_ff == TSR_ADDR_SETUP);
   assign clear_req = wr_setup && reg_wdata[TSR_SET_CLEAR];
   // ----------------------------------------
   // Conversion tick crossing
   // ----------------------------------------
   // Three stages; the agreed level is taken only once stages two and three match
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tick_s1_ff <= 1'b0;
         tick_s2_ff <= 1'b0;
         tick_s3_ff <= 1'b0;
         tick_lvl_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         tick_s1_ff <= conv_tick;
         tick_s2_ff <= tick_s1_ff;
         tick_s3_ff <= tick_s2_ff;
         if (tick_s2_ff == tick_s3_ff)
            tick_lvl_ff <= tick_s3_ff;
      end
   end
   assign tick_rise = tick_s2_ff && tick_s3_ff && !tick_lvl_ff;

   // ----------------------------------------
   // Pointer and write acknowledge
   // ----------------------------------------
   // Pointer powers up on the capability register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         ptr_ff <= TSR_ADDR_CAP;
      else if (clk_en && ptr_wr)
         ptr_ff <= ptr_addr;
   end

   // Every write is answered, even one the bank refuses to store
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         wr_ack_ff <= 1'b0;
      else if (clk_en)
         wr_ack_ff <= reg_wr;
   end

   // ----------------------------------------
   // Limit registers
   // ----------------------------------------
   // Unimplemented bits are masked so they always read zero
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         upper_ff <= TSR_LIMIT_RESET;
         lower_ff <= TSR_LIMIT_RESET;
         crit_ff <= TSR_LIMIT_RESET;
      end
      else if (clk_en && reg_wr)
      begin
         if (ptr_ff == TSR_ADDR_UPPER && !alarm_lock_ff)
            upper_ff <= reg_wdata & TSR_LIMIT_MASK;
         if (ptr_ff == TSR_ADDR_LOWER && !alarm_lock_ff)
            lower_ff <= reg_wdata & TSR_LIMIT_MASK;
         if (ptr_ff == TSR_ADDR_CRIT && !crit_freeze_ff)
            crit_ff <= reg_wdata & TSR_LIMIT_MASK;
      end
   end

   // ----------------------------------------
   // Setup register
   // ----------------------------------------
   // Locks are sticky; only reset releases them
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         crit_freeze_ff <= 1'b0;
         alarm_lock_ff <= 1'b0;
      end
      else if (clk_en && wr_setup)
      begin
         if (reg_wdata[TSR_SET_CRIT_FREEZE])
            crit_freeze_ff <= 1'b1;
         if (reg_wdata[TSR_SET_ALARM_LOCK])
            alarm_lock_ff <= 1'b1;
      end
   end

   // Halt may always be cleared, but never set under a lock
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         halt_ff <= 1'b0;
      else if (clk_en && wr_setup)
      begin
         if (!reg_wdata[TSR_SET_HALT])
            halt_ff <= 1'b0;
         else if (!lock_any)
            halt_ff <= 1'b1;
      end
   end

   // Mode fields frozen while any lock holds; enable starts low
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hysteresis_select_ff <= 2'b00;
         alert_en_ff <= 1'b0;
         pol_ff <= 1'b0;
         mode_ff <= 1'b0;
         crit_only_ff <= 1'b0;
      end
      else if (clk_en && wr_setup && !lock_any)
      begin
         hysteresis_select_ff <= reg_wdata[TSR_SET_HYSTERESIS_SELECT_HI:TSR_SET_HYSTERESIS_SELECT_LO];
         alert_en_ff <= reg_wdata[TSR_SET_ALERT_EN];
         pol_ff <= reg_wdata[TSR_SET_POL];
         mode_ff <= reg_wdata[TSR_SET_MODE];
         crit_only_ff <= reg_wdata[TSR_SET_CRIT_ONLY];
      end
   end

   // ----------------------------------------
   // Temperature capture
   // ----------------------------------------
   // The converter word is assumed steady around its tick, so it is not synchronised
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         temp_ff <= TSR_TEMP_RESET;
      else if (clk_en && tick_rise && !halt_ff)
         temp_ff <= conv_temp;
   end

   // ----------------------------------------
   // Limit comparison with hysteresis
   // ----------------------------------------
   always_comb
   begin
      case (hysteresis_select_ff)
         2'b00: hysteresis_select_amt = TSR_HYSTERESIS_SELECT_NONE;
         2'b01: hysteresis_select_amt = TSR_HYSTERESIS_SELECT_SMALL;
         2'b10: hysteresis_select_amt = TSR_HYSTERESIS_SELECT_MID;
         default: hysteresis_select_amt = TSR_HYSTERESIS_SELECT_LARGE;
      endcase
   end
   // Limits share the temperature scale; their low two bits are zero
   assign t_s = {{2{temp_ff[12]}}, temp_ff};
   assign hi_s = {{2{upper_ff[12]}}, upper_ff[12:0]};
   assign lo_s = {{2{lower_ff[12]}}, lower_ff[12:0]};
   assign cr_s = {{2{crit_ff[12]}}, crit_ff[12:0]};
   assign hy_s = $signed(hysteresis_select_amt);
   // Flags trip only past the limit and release once back at the far edge of the hysteresis band.
   // Limit changes take effect at once, not at the next sample.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         above_crit_ff <= 1'b0;
         above_high_ff <= 1'b0;
         below_low_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         if (t_s > cr_s)
            above_crit_ff <= 1'b1;
         else if (t_s <= cr_s - hy_s)
            above_crit_ff <= 1'b0;
         if (t_s > hi_s)
            above_high_ff <= 1'b1;
         else if (t_s <= hi_s - hy_s)
            above_high_ff <= 1'b0;
         if (t_s < lo_s)
            below_low_ff <= 1'b1;
         else if (t_s >= lo_s + hy_s)
            below_low_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // Event logic
   // ----------------------------------------
   assign window_out = crit_only_ff ? 1'b0 : (above_high_ff | below_low_ff);
   // Interrupt latch: any window crossing sets it; set wins over clear.
   // A clear seen above critical waits until the temperature drops below.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         window_prev_ff <= 1'b0;
         latch_ff <= 1'b0;
         clr_pend_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         window_prev_ff <= window_out;
         if (window_out != window_prev_ff)
            latch_ff <= 1'b1;
         else if (clear_req && mode_ff && !above_crit_ff)
            latch_ff <= 1'b0;
         else if (clr_pend_ff && !above_crit_ff)
            latch_ff <= 1'b0;
         if (clear_req && mode_ff && above_crit_ff)
            clr_pend_ff <= 1'b1;
         else if (!above_crit_ff || !mode_ff)
            clr_pend_ff <= 1'b0;
      end
   end
   // Interrupt mode follows the latch, comparator mode the window itself
   always_comb
   begin
      if (mode_ff)
         nxt_event = latch_ff | above_crit_ff;
      else
         nxt_event = window_out | above_crit_ff;
   end
   // Shutdown freezes the alert state; only a clear may drop it meanwhile
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         event_ff <= 1'b0;
      else if (clk_en)
      begin
         if (!halt_ff)
            event_ff <= nxt_event;
         else if (clear_req && mode_ff && !above_crit_ff)
            event_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // Alert pin
   // ----------------------------------------
   // Open-drain: the pin is only ever pulled low, so output stays zero
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         alert_out_ff <= 1'b0;
         alert_oe_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         alert_out_ff <= 1'b0;
         if (!alert_en_ff)
            alert_oe_ff <= pol_ff;
         else
            alert_oe_ff <= pol_ff ? !event_ff : event_ff;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_comb
   begin
      setup_rd = 16'h0000;
      setup_rd[TSR_SET_HYSTERESIS_SELECT_HI:TSR_SET_HYSTERESIS_SELECT_LO] = hysteresis_select_ff;
      setup_rd[TSR_SET_HALT] = halt_ff;
      setup_rd[TSR_SET_CRIT_FREEZE] = crit_freeze_ff;
      setup_rd[TSR_SET_ALARM_LOCK] = alarm_lock_ff;
      setup_rd[TSR_SET_CLEAR] = 1'b0;
      setup_rd[TSR_SET_STATE_COPY] = alert_en_ff & event_ff;
      setup_rd[TSR_SET_ALERT_EN] = alert_en_ff;
      setup_rd[TSR_SET_CRIT_ONLY] = crit_only_ff;
      setup_rd[TSR_SET_POL] = pol_ff;
      setup_rd[TSR_SET_MODE] = mode_ff;
   end

   always_comb
   begin
      case (ptr_ff)
         TSR_ADDR_CAP: nxt_rd_data = TSR_CAP_VALUE;
         TSR_ADDR_SETUP: nxt_rd_data = setup_rd;
         TSR_ADDR_UPPER: nxt_rd_data = upper_ff;
         TSR_ADDR_LOWER: nxt_rd_data = lower_ff;
         TSR_ADDR_CRIT: nxt_rd_data = crit_ff;
         TSR_ADDR_TEMP: nxt_rd_data = {above_crit_ff, above_high_ff, below_low_ff, temp_ff};
         TSR_ADDR_MAKER: nxt_rd_data = MAKER_CODE;
         default: nxt_rd_data = PART_CODE;
      endcase
   end

   // Registered so the serial engine sees a steady word a cycle after the pointer moves
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_data_ff <= TSR_CAP_VALUE;
      else if (clk_en)
         rd_data_ff <= nxt_rd_data;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence clear_above_crit_s;
      clk_en && clear_req && mode_ff && above_crit_ff && !halt_ff;
   endsequence
   sequence event_held_s;
      clk_en ##1 event_ff;
   endsequence
   maker_fixed_a: assert property (clk_en && ptr_ff == TSR_ADDR_MAKER |=> rd_data_ff == MAKER_CODE)
      else $error("maker code read wrong");
   setup_rsvd_a: assert property (clk_en && ptr_ff == TSR_ADDR_SETUP |=> rd_data_ff[15:11] == 5'h00 && !rd_data_ff[5])
      else $error("setup reserved or clear bit read nonzero");
   cap_value_a: assert property (clk_en && ptr_ff == TSR_ADDR_CAP |=> rd_data_ff == TSR_CAP_VALUE)
      else $error("capability value wrong");
   crit_lock_a: assert property (clk_en && reg_wr && ptr_ff == TSR_ADDR_CRIT && crit_freeze_ff |=> $stable(crit_ff))
      else $error("locked critical limit changed");
   lock_sticky_a: assert property (alarm_lock_ff |=> alarm_lock_ff)
      else $error("alarm lock released");
   halt_refuse_a: assert property (clk_en && wr_setup && lock_any && !halt_ff |=> !halt_ff)
      else $error("halt set under lock");
   halt_hold_a: assert property (clk_en && halt_ff |=> $stable(temp_ff))
      else $error("temperature moved during halt");
   write_ack_a: assert property (clk_en && reg_wr |=> wr_ack_ff)
      else $error("write not acknowledged");
   alert_off_a: assert property (clk_en && !alert_en_ff && !wr_setup |=> alert_oe_ff == pol_ff && !alert_out_ff)
      else $error("disabled alert pin wrong");
   trip_flag_a: assert property (clk_en && ptr_ff == TSR_ADDR_TEMP |=> rd_data_ff[15] == $past(above_crit_ff))
      else $error("critical flag not reported");
   crit_clear_a: assert property (clear_above_crit_s |-> ##1 event_held_s)
      else $error("alert dropped on clear above critical");
endmodule : tsr_register_bank
`default_nettype wire

//--- tb/tsr_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Converter model: sample strobe and result bundle
// ----------------------------------------
module tsr_conv_model
(
   output var logic conv_tick,
   output var logic [12:0] conv_temp
);
   // Strobe rests low between samples
   initial
   begin
      conv_tick = 1'b0;
      conv_temp = 13'h0000;
   end

   // One sample frame of 837 ns, phase unrelated to the bank clock
   task automatic sample(input logic [12:0] t);
      #37;
      conv_temp = t;
      conv_tick = 1'b1;
      #400;
      conv_tick = 1'b0;
      #400;
      // Result is stale once the frame is over, so it no longer shows the value
      conv_temp = ~t;
   endtask : sample
endmodule : tsr_conv_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module testbench;
   import tsr_pkg::*;
   // ----------------------------------------
   // Signals and constants
   // ----------------------------------------
   localparam logic [15:0] MAKER_C = 16'h3C5A; // Arbitrary value
   localparam logic [15:0] PART_C = 16'h0E17; // Arbitrary value
   localparam logic [12:0] HI = 13'h0190;
   localparam logic [12:0] LO = 13'h1E70;
   localparam logic [12:0] CR = 13'h0320;
   logic clk, rst_b, clk_en, ptr_wr, reg_wr, wr_ack, alert_out, alert_oe;
   logic [2:0] ptr_addr;
   logic [15:0] reg_wdata, rd_data, d, e;
   logic conv_tick;
   logic [12:0] conv_temp, t;
   logic [31:0] rng_state = 32'h0000_0030;
   logic [31:0] r;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;

   tsr_register_bank #(.MAKER_CODE(MAKER_C), .PART_CODE(PART_C)) i_dut
   (
      .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .ptr_wr(ptr_wr), .ptr_addr(ptr_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .conv_tick(conv_tick), .conv_temp(conv_temp),
      .rd_data_ff(rd_data), .wr_ack_ff(wr_ack), .alert_out_ff(alert_out), .alert_oe_ff(alert_oe)
   );
   tsr_conv_model i_conv (.conv_tick(conv_tick), .conv_temp(conv_temp));

   // Bench clock, 100 ns period
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Hang guard: the whole run needs under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         complete_run();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function logic [31:0] next_rand();
      rng_state ^= rng_state << 13;
      rng_state ^= rng_state >> 17;
      rng_state ^= rng_state << 5;
      return rng_state;
   endfunction : next_rand

   function automatic logic [15:0] exp_temp(input logic [12:0] v);
      return {$signed(v) > $signed(CR), $signed(v) > $signed(HI), $signed(v) < $signed(LO), v};
   endfunction : exp_temp

   function automatic logic [15:0] reset_val(input int a);
      case (a)
         0: return 16'h0077;
         6: return MAKER_C;
         7: return PART_C;
         default: return 16'h0000;
      endcase
   endfunction : reset_val

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   task automatic set_ptr(input logic [2:0] a);
      @(posedge clk);
      ptr_wr <= 1'b1;
      ptr_addr <= a;
      @(posedge clk);
      ptr_wr <= 1'b0;
   endtask : set_ptr

   // Pointer then word; the ack stands for one cycle only, so it is looked at then
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      set_ptr(a);
      reg_wr <= 1'b1;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
      `CHK(wr_ack, 1'b1);
   endtask : wr

   task automatic rchk(input logic [2:0] a, input logic [15:0] e);
      set_ptr(a);
      repeat (2) @(posedge clk);
      #1;
      d = rd_data;
      `CHK(d, e);
   endtask : rchk

   task automatic tsamp(input logic [12:0] v);
      i_conv.sample(v);
      repeat (6) @(posedge clk);
      #1;
   endtask : tsamp

   task automatic test_end(input string name);
      $display("test %s finished", name);
   endtask : test_end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      clk_en = 1'b1;
      ptr_wr = 1'b0;
      ptr_addr = 3'h0;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      rst_b = 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      `CHK(rd_data, 16'h0077);
      `CHK(alert_oe, 1'b0);
      for (int a = 0; a < 8; a++)
         rchk(a[2:0], reset_val(a));
      test_end("reset");
      // Read-only places keep their contents under random writes
      for (int a = 4; a < 8; a++)
      begin
         r = next_rand();
         wr((a == 4) ? 3'h0 : a[2:0], r[15:0]);
         rchk((a == 4) ? 3'h0 : a[2:0], reset_val((a == 4) ? 0 : a));
      end
      wr(3'h1, 16'hF830);
      rchk(3'h1, 16'h0000);
      test_end("read_only");
      // Limits keep only their implemented bits
      for (int i = 0; i < 6; i++)
      begin
         r = next_rand();
         wr(3'h2 + 3'(i % 3), r[15:0]);
         rchk(3'h2 + 3'(i % 3), r[15:0] & 16'h1FFC);
      end
      wr(3'h2, {3'h0, HI});
      wr(3'h3, {3'h0, LO});
      wr(3'h4, {3'h0, CR});
      wr(3'h1, 16'h0008);
      test_end("limits");
      // Edges of the window first, then random readings
      for (int i = 0; i < 11; i++)
      begin
         r = next_rand();
         case (i)
            0: t = HI;
            1: t = HI + 13'h0001;
            2: t = LO;
            3: t = LO - 13'h0001;
            4: t = CR + 13'h0001;
            default: t = r[12:0];
         endcase
         tsamp(t);
         e = exp_temp(t);
         `CHK(alert_oe, |e[15:13]);
         rchk(3'h5, e);
         rchk(3'h1, 16'h0008 | {11'h000, |e[15:13], 4'h0});
      end
      test_end("comparator");
      // Every enable and polarity, with and without an event
      for (int i = 0; i < 8; i++)
      begin
         if (i % 4 == 0)
            tsamp((i < 4) ? 13'h0200 : 13'h0000);
         wr(3'h1, {12'h000, i[1], 1'b0, i[0], 1'b0});
         repeat (3) @(posedge clk);
         #1;
         `CHK(alert_oe, i[1] ? (i[0] ? (i >= 4) : (i < 4)) : i[0]);
         `CHK(alert_out, 1'b0);
         rchk(3'h1, {11'h000, i[1] & (i < 4), i[1], 1'b0, i[0], 1'b0});
      end
      tsamp(13'h0200);
      wr(3'h1, 16'h0028);
      repeat (3) @(posedge clk);
      #1;
      `CHK(alert_oe, 1'b1);
      test_end("polarity");
      // Interrupt mode: latch, clear, and a clear held above critical
      tsamp(13'h0000);
      wr(3'h1, 16'h0009);
      // Drop what the latch caught in comparator mode, so the crossing below counts
      wr(3'h1, 16'h0029);
      repeat (3) @(posedge clk);
      #1;
      `CHK(alert_oe, 1'b0);
      tsamp(13'h0200);
      tsamp(13'h0000);
      `CHK(alert_oe, 1'b1);
      wr(3'h1, 16'h0029);
      repeat (3) @(posedge clk);
      #1;
      `CHK(alert_oe, 1'b0);
      rchk(3'h1, 16'h0009);
      tsamp(13'h0400);
      wr(3'h1, 16'h0029);
      repeat (3) @(posedge clk);
      #1;
      `CHK(alert_oe, 1'b1);
      // Leaving the critical band runs the held clear, though the high alarm still stands
      tsamp(13'h0280);
      `CHK(alert_oe, 1'b0);
      test_end("interrupt");
      // Halt holds the last reading
      wr(3'h1, 16'h0008);
      tsamp(13'h0111);
      wr(3'h1, 16'h0108);
      tsamp(13'h0055);
      rchk(3'h5, exp_temp(13'h0111));
      wr(3'h1, 16'h0008);
      tsamp(13'h0055);
      rchk(3'h5, exp_temp(13'h0055));
      for (int h = 0; h < 4; h++)
      begin
         wr(3'h1, 16'(h) << 9);
         rchk(3'h1, 16'(h) << 9);
      end
      test_end("halt");
      // Locks: one-way, and they guard limits and mode bits
      wr(3'h1, 16'h0100);
      wr(3'h1, 16'h0140);
      rchk(3'h1, 16'h0140);
      wr(3'h1, 16'h0040);
      rchk(3'h1, 16'h0040);
      wr(3'h1, 16'h074F);
      rchk(3'h1, 16'h0040);
      wr(3'h2, 16'h0AAC);
      rchk(3'h2, {3'h0, HI});
      wr(3'h4, 16'h0100);
      rchk(3'h4, 16'h0100);
      wr(3'h1, 16'h0080);
      rchk(3'h1, 16'h00C0);
      wr(3'h4, 16'h0200);
      rchk(3'h4, 16'h0100);
      test_end("locks");
      // Enable low: a pointer move is ignored and the read word holds
      @(posedge clk);
      clk_en <= 1'b0;
      ptr_wr <= 1'b1;
      ptr_addr <= 3'h6;
      @(posedge clk);
      ptr_wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK(rd_data, 16'h0100);
      @(posedge clk);
      clk_en <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK(rd_data, 16'h0100);
      test_end("clock_enable");
      // Reset in mid-run is the only way out of the locks
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      `CHK(rd_data, 16'h0077);
      `CHK(alert_oe, 1'b0);
      rchk(3'h1, 16'h0000);
      test_end("second_reset");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
